// ===== hdl/pfsb_consts.vh
// pfsb_consts.vh: command codes, bit positions and mask defaults for the
// fault/status register bank. assumes inclusion by bare name from hdl/.
`ifndef PFSB_CONSTS_VH
`define PFSB_CONSTS_VH
// command codes used on the internal register port
`define PFSB_CMD_VOUT 8'h7a
`define PFSB_CMD_IOUT 8'h7b
`define PFSB_CMD_INPUT 8'h7c
`define PFSB_CMD_TEMP 8'h7d
`define PFSB_CMD_CML 8'h7e
`define PFSB_CMD_VEND 8'h80
`define PFSB_CMD_PINS 8'he5
`define PFSB_CMD_COMMON 8'hef
// supported bit masks per status byte
`define PFSB_SUP_VOUT 8'hfe
`define PFSB_SUP_IOUT 8'ha0
`define PFSB_SUP_INPUT 8'ha2
`define PFSB_SUP_TEMP 8'hd0
`define PFSB_SUP_CML 8'hfb
`define PFSB_SUP_VEND 8'hfd
// live, unlatched input bit and fault-log bit positions
`define PFSB_BIT_INPUT_OFF 3
`define PFSB_BIT_VEND_LOG 3
// alert mask and status byte reset values
`define PFSB_MASK_RST_STD 8'h00
`define PFSB_MASK_RST_VEND 8'h11
`define PFSB_STATUS_RST 8'h00
`endif

// ===== hdl/pfsb_w1c_byte.v
// pfsb_w1c_byte.v: one latched status byte with write-one-to-clear.
// assumes event inputs are synchronous to clock_in.
`default_nettype none
module pfsb_w1c_byte #(
  parameter [7:0] SUPPORTED = 8'hff,
  parameter [7:0] STICKY_ONLY = 8'h00
) (
  input wire clock_in,
  input wire srst_in,
  input wire [7:0] event_in,
  input wire [7:0] w1c_in,
  input wire clear_all_in,
  input wire [7:0] special_clr_in,
  output reg [7:0] latched_out
);
  reg [7:0] latched_next;
  // clears first, then events re-set, so an event in the clear cycle wins
  always @* begin
    latched_next = latched_out;
    if (clear_all_in) begin
      latched_next = 8'h00;
    end
    latched_next = latched_next & ~(w1c_in & ~STICKY_ONLY);
    latched_next = latched_next & ~special_clr_in;
    latched_next = (latched_next | event_in) & SUPPORTED;
  end
  always @(posedge clock_in) begin
    if (srst_in) begin
      latched_out <= 8'h00;
    end else begin
      latched_out <= latched_next;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/pfsb_fault_status_bank.v
// pfsb_fault_status_bank.v: latched fault/status bytes, pin and common
// readback, alert masking and alert generation for a dual-output controller.
// assumes the serial engine delivers one-cycle write/read/command strobes
// synchronous to clock_in; condition inputs come from asynchronous logic.
//
// Notes on behaviour
// RULE_01 - vout byte: ov/uv faults, warnings, ton, toff
// RULE_02 - iout byte: oc fault bit7, warning bit5
// RULE_03 - input byte: bits 7,5,3,1 supported
// RULE_04 - input bit3 live, never raises alert
// RULE_05 - temperature byte kept per page
// RULE_06 - cml byte: bits 7..3,1,0; bit2 zero
// RULE_07 - host stops on persistent memory/processor fault
// RULE_08 - writing one clears that bit only
// RULE_09 - supported fault bits raise alert
// RULE_10 - vendor byte bits 7..2 and 0
// RULE_11 - any vendor bit sets summary bit
// RULE_12 - fault log bit cleared by command only
// RULE_13 - pin word carries supply, adc, pins
// RULE_14 - pin word read-only, bits 13:12 zero
// RULE_15 - common byte flags, bit2 reserved
// RULE_16 - common byte read-only, writes ignored
// RULE_17 - clear-all clears everything but the vendor log bit, live faults re-set
// RULE_18 - status word vendor summary bit
// RULE_19 - per-register alert mask gates alert only
// RULE_20 - latched bits hold; unsupported bits read zero
// RULE_21 - alert held while unmasked bit set
`default_nettype none
`include "pfsb_consts.vh"
module pfsb_fault_status_bank (
  input wire clock_in,
  input wire srst_in,
  input wire [7:0] cmd_code_in,
  input wire page_in,
  input wire write_strobe_in,
  input wire read_strobe_in,
  input wire [7:0] write_data_in,
  input wire mask_write_in,
  input wire clear_faults_in,
  input wire fault_history_erase_cmd_in,
  input wire [7:0] vout_event0_in,
  input wire [7:0] vout_event1_in,
  input wire [7:0] iout_event0_in,
  input wire [7:0] iout_event1_in,
  input wire [7:0] input_event_in,
  input wire [7:0] temp_event0_in,
  input wire [7:0] temp_event1_in,
  input wire [7:0] cml_event_in,
  input wire [7:0] vend_event_in,
  input wire [15:0] pin_state_in,
  input wire [7:0] common_flags_in,
  output reg [15:0] read_data_out,
  output reg read_valid_out,
  output reg alert_n_out,
  output reg vendor_summary_out
);
  ////////////////////////////////////////////////////////////////////////
  // input synchronisers for asynchronous conditions
  reg [127:0] cond_meta_reg; // first stage, read by second stage only
  reg [127:0] cond_sync_reg; // second stage, safe for logic
  wire [127:0] cond_raw;
  assign cond_raw = {vout_event0_in, vout_event1_in, iout_event0_in, iout_event1_in,
    input_event_in, temp_event0_in, temp_event1_in, cml_event_in, vend_event_in,
    pin_state_in, common_flags_in, 32'h0000_0000};
  // two-flop crossing; a condition shorter than a cycle may be missed
  always @(posedge clock_in) begin
    if (srst_in) begin
      cond_meta_reg <= 128'h0;
      cond_sync_reg <= 128'h0;
    end else begin
      cond_meta_reg <= cond_raw;
      cond_sync_reg <= cond_meta_reg;
    end
  end
  wire [7:0] s_vout0 = cond_sync_reg[127:120];
  wire [7:0] s_vout1 = cond_sync_reg[119:112];
  wire [7:0] s_iout0 = cond_sync_reg[111:104];
  wire [7:0] s_iout1 = cond_sync_reg[103:96];
  wire [7:0] s_input = cond_sync_reg[95:88];
  wire [7:0] s_temp0 = cond_sync_reg[87:80];
  wire [7:0] s_temp1 = cond_sync_reg[79:72];
  wire [7:0] s_cml = cond_sync_reg[71:64];
  wire [7:0] s_vend = cond_sync_reg[63:56];
  wire [15:0] s_pins = cond_sync_reg[55:40];
  wire [7:0] s_common = cond_sync_reg[39:32];

  ////////////////////////////////////////////////////////////////////////
  // write decode: one w1c vector per status byte, paged where needed
  wire wr = write_strobe_in & ~mask_write_in;
  wire [7:0] wd = write_data_in;
  // RULE_08 write-one-to-clear strobes
  wire [7:0] w1c_vout0 = (wr && cmd_code_in == `PFSB_CMD_VOUT && !page_in) ? wd : 8'h00;
  wire [7:0] w1c_vout1 = (wr && cmd_code_in == `PFSB_CMD_VOUT && page_in) ? wd : 8'h00;
  wire [7:0] w1c_iout0 = (wr && cmd_code_in == `PFSB_CMD_IOUT && !page_in) ? wd : 8'h00;
  wire [7:0] w1c_iout1 = (wr && cmd_code_in == `PFSB_CMD_IOUT && page_in) ? wd : 8'h00;
  wire [7:0] w1c_input = (wr && cmd_code_in == `PFSB_CMD_INPUT) ? wd : 8'h00;
  wire [7:0] w1c_temp0 = (wr && cmd_code_in == `PFSB_CMD_TEMP && !page_in) ? wd : 8'h00;
  wire [7:0] w1c_temp1 = (wr && cmd_code_in == `PFSB_CMD_TEMP && page_in) ? wd : 8'h00;
  wire [7:0] w1c_cml = (wr && cmd_code_in == `PFSB_CMD_CML) ? wd : 8'h00;
  wire [7:0] w1c_vend = (wr && cmd_code_in == `PFSB_CMD_VEND) ? wd : 8'h00;
  // fault log bit only responds to its own erase command
  wire [7:0] log_clr = fault_history_erase_cmd_in ? (8'h01 << `PFSB_BIT_VEND_LOG) : 8'h00;
  localparam [7:0] LOG_BIT = 8'h01 << `PFSB_BIT_VEND_LOG;
  localparam [7:0] INPUT_OFF_BIT = 8'h01 << `PFSB_BIT_INPUT_OFF;

  ////////////////////////////////////////////////////////////////////////
  // latched status bytes
  wire [7:0] st_vout0, st_vout1, st_iout0, st_iout1, st_input;
  wire [7:0] st_temp0, st_temp1, st_cml, st_vend;
  // RULE_01 vout byte latches
  pfsb_w1c_byte #(.SUPPORTED(`PFSB_SUP_VOUT), .STICKY_ONLY(8'h00)) u_vout0 (
    .clock_in(clock_in), .srst_in(srst_in), .event_in(s_vout0), .w1c_in(w1c_vout0),
    .clear_all_in(clear_faults_in), .special_clr_in(8'h00), .latched_out(st_vout0));
  pfsb_w1c_byte #(.SUPPORTED(`PFSB_SUP_VOUT), .STICKY_ONLY(8'h00)) u_vout1 (
    .clock_in(clock_in), .srst_in(srst_in), .event_in(s_vout1), .w1c_in(w1c_vout1),
    .clear_all_in(clear_faults_in), .special_clr_in(8'h00), .latched_out(st_vout1));
  // RULE_02 iout byte latches
  pfsb_w1c_byte #(.SUPPORTED(`PFSB_SUP_IOUT), .STICKY_ONLY(8'h00)) u_iout0 (
    .clock_in(clock_in), .srst_in(srst_in), .event_in(s_iout0), .w1c_in(w1c_iout0),
    .clear_all_in(clear_faults_in), .special_clr_in(8'h00), .latched_out(st_iout0));
  pfsb_w1c_byte #(.SUPPORTED(`PFSB_SUP_IOUT), .STICKY_ONLY(8'h00)) u_iout1 (
    .clock_in(clock_in), .srst_in(srst_in), .event_in(s_iout1), .w1c_in(w1c_iout1),
    .clear_all_in(clear_faults_in), .special_clr_in(8'h00), .latched_out(st_iout1));
  // RULE_03 input byte; bit 3 excluded here and merged live below
  pfsb_w1c_byte #(.SUPPORTED(`PFSB_SUP_INPUT & ~INPUT_OFF_BIT), .STICKY_ONLY(8'h00)) u_input (
    .clock_in(clock_in), .srst_in(srst_in), .event_in(s_input), .w1c_in(w1c_input),
    .clear_all_in(clear_faults_in), .special_clr_in(8'h00), .latched_out(st_input));
  // RULE_05 one temperature byte per page
  pfsb_w1c_byte #(.SUPPORTED(`PFSB_SUP_TEMP), .STICKY_ONLY(8'h00)) u_temp0 (
    .clock_in(clock_in), .srst_in(srst_in), .event_in(s_temp0), .w1c_in(w1c_temp0),
    .clear_all_in(clear_faults_in), .special_clr_in(8'h00), .latched_out(st_temp0));
  pfsb_w1c_byte #(.SUPPORTED(`PFSB_SUP_TEMP), .STICKY_ONLY(8'h00)) u_temp1 (
    .clock_in(clock_in), .srst_in(srst_in), .event_in(s_temp1), .w1c_in(w1c_temp1),
    .clear_all_in(clear_faults_in), .special_clr_in(8'h00), .latched_out(st_temp1));
  // RULE_06 cml byte, bit 2 unsupported
  pfsb_w1c_byte #(.SUPPORTED(`PFSB_SUP_CML), .STICKY_ONLY(8'h00)) u_cml (
    .clock_in(clock_in), .srst_in(srst_in), .event_in(s_cml), .w1c_in(w1c_cml),
    .clear_all_in(clear_faults_in), .special_clr_in(8'h00), .latched_out(st_cml));
  // RULE_10 RULE_12 vendor byte, log bit immune to w1c and clear-all
  pfsb_w1c_byte #(.SUPPORTED(`PFSB_SUP_VEND), .STICKY_ONLY(LOG_BIT)) u_vend (
    .clock_in(clock_in), .srst_in(srst_in), .event_in(s_vend), .w1c_in(w1c_vend),
    .clear_all_in(1'b0), .special_clr_in(log_clr | (clear_faults_in ? ~LOG_BIT : 8'h00)),
    .latched_out(st_vend));
  // RULE_04 live input bit, not latched
  wire [7:0] input_view = st_input | (s_input & INPUT_OFF_BIT);

  ////////////////////////////////////////////////////////////////////////
  // alert masks, written as command code plus mask byte
  reg [7:0] mask_vout_reg, mask_iout_reg, mask_input_reg;
  reg [7:0] mask_temp_reg, mask_cml_reg, mask_vend_reg;
  // RULE_19 mask registers; pin and common words are not maskable
  always @(posedge clock_in) begin
    if (srst_in) begin
      mask_vout_reg <= `PFSB_MASK_RST_STD;
      mask_iout_reg <= `PFSB_MASK_RST_STD;
      mask_input_reg <= `PFSB_MASK_RST_STD;
      mask_temp_reg <= `PFSB_MASK_RST_STD;
      mask_cml_reg <= `PFSB_MASK_RST_STD;
      mask_vend_reg <= `PFSB_MASK_RST_VEND;
    end else if (write_strobe_in && mask_write_in) begin
      case (cmd_code_in)
        `PFSB_CMD_VOUT: mask_vout_reg <= wd;
        `PFSB_CMD_IOUT: mask_iout_reg <= wd;
        `PFSB_CMD_INPUT: mask_input_reg <= wd;
        `PFSB_CMD_TEMP: mask_temp_reg <= wd;
        `PFSB_CMD_CML: mask_cml_reg <= wd;
        `PFSB_CMD_VEND: mask_vend_reg <= wd;
        default: mask_vout_reg <= mask_vout_reg; // unmaskable: ignored
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // alert: level from unmasked latched bits, live input bit excluded
  // RULE_09 RULE_21 alert combine
  wire alert_any = |(st_vout0 & ~mask_vout_reg) | |(st_vout1 & ~mask_vout_reg) |
    |(st_iout0 & ~mask_iout_reg) | |(st_iout1 & ~mask_iout_reg) |
    |(st_input & ~mask_input_reg) |
    |(st_temp0 & ~mask_temp_reg) | |(st_temp1 & ~mask_temp_reg) |
    |(st_cml & ~mask_cml_reg) | |(st_vend & ~mask_vend_reg);
  // RULE_17 clear-all releases alert for a cycle; live faults re-latch
  always @(posedge clock_in) begin
    if (srst_in) begin
      alert_n_out <= 1'b1;
      vendor_summary_out <= 1'b0;
    end else begin
      alert_n_out <= clear_faults_in ? 1'b1 : ~alert_any;
      // RULE_11 RULE_18 vendor summary bit
      vendor_summary_out <= |st_vend;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux; register answer one cycle after the read strobe
  reg [15:0] rd_next;
  // RULE_13 RULE_14 RULE_15 RULE_16 RULE_20 read views
  always @* begin
    case (cmd_code_in)
      `PFSB_CMD_VOUT: rd_next = {8'h00, page_in ? st_vout1 : st_vout0};
      `PFSB_CMD_IOUT: rd_next = {8'h00, page_in ? st_iout1 : st_iout0};
      `PFSB_CMD_INPUT: rd_next = {8'h00, input_view};
      `PFSB_CMD_TEMP: rd_next = {8'h00, page_in ? st_temp1 : st_temp0};
      `PFSB_CMD_CML: rd_next = {8'h00, st_cml};
      `PFSB_CMD_VEND: rd_next = {8'h00, st_vend};
      `PFSB_CMD_PINS: rd_next = s_pins & 16'hcfff;
      `PFSB_CMD_COMMON: rd_next = {8'h00, s_common[7:3], 1'b0, s_common[1:0]};
      default: rd_next = 16'h0000;
    endcase
  end
  always @(posedge clock_in) begin
    if (srst_in) begin
      read_data_out <= 16'h0000;
      read_valid_out <= 1'b0;
    end else begin
      read_valid_out <= read_strobe_in;
      if (read_strobe_in) begin
        read_data_out <= rd_next;
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/pfsb_props.sv
// checker for the fault/status bank: reserved bits, read timing, alert release.
// assumes it is bound to the bank top and sees only its ports.
`default_nettype none
`include "pfsb_consts.vh"
module pfsb_props (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic read_strobe_in,
  input wire logic clear_faults_in,
  input wire logic [15:0] read_data_out,
  input wire logic read_valid_out,
  input wire logic alert_n_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock_in); endclocking
  default disable iff (srst_in);
  logic [7:0] last_cmd; // code seen at the previous edge, i.e. of the read in flight
  ////////////////////////////////////////////////////////////////////////////
  // helper register, plain delay so the properties stay short
  always_ff @(posedge clock_in) begin
    last_cmd <= cmd_code_in;
  end
  ////////////////////////////////////////////////////////////////////////////
  answer_one_cycle_a: assert property (read_strobe_in |=> read_valid_out)
    else $error("read answer late");
  answer_has_cause_a: assert property (read_valid_out |-> $past(read_strobe_in))
    else $error("read answer without request");
  vout_zero_a: assert property (read_valid_out && last_cmd == `PFSB_CMD_VOUT
    |-> (read_data_out & 16'hff01) == 16'h0000) else $error("vout unused bits set");
  iout_zero_a: assert property (read_valid_out && last_cmd == `PFSB_CMD_IOUT
    |-> (read_data_out & 16'hff5f) == 16'h0000) else $error("iout unused bits set");
  input_zero_a: assert property (read_valid_out && last_cmd == `PFSB_CMD_INPUT
    |-> (read_data_out & 16'hff55) == 16'h0000) else $error("input unused bits set");
  temp_zero_a: assert property (read_valid_out && last_cmd == `PFSB_CMD_TEMP
    |-> (read_data_out & 16'hff2f) == 16'h0000) else $error("temp unused bits set");
  cml_zero_a: assert property (read_valid_out && last_cmd == `PFSB_CMD_CML
    |-> (read_data_out & 16'hff04) == 16'h0000) else $error("cml unused bits set");
  vendor_zero_a: assert property (read_valid_out && last_cmd == `PFSB_CMD_VEND
    |-> (read_data_out & 16'hff02) == 16'h0000) else $error("vendor unused bits set");
  pins_reserved_a: assert property (read_valid_out && last_cmd == `PFSB_CMD_PINS
    |-> read_data_out[13:12] == 2'b00) else $error("pin word reserved bits set");
  common_reserved_a: assert property (read_valid_out && last_cmd == `PFSB_CMD_COMMON
    |-> (read_data_out & 16'hff04) == 16'h0000) else $error("common byte reserved bits set");
  clear_releases_a: assert property (clear_faults_in |=> alert_n_out)
    else $error("alert held through clear");
endmodule
`default_nettype wire

// ===== sim/pfsb_host_model.sv
// host model: strobed reads, writes and commands toward the status bank.
// assumes the bank answers one cycle after a read strobe.
`default_nettype none
module pfsb_host_model (
  input wire logic clock_in,
  input wire logic [15:0] read_data_in,
  input wire logic read_valid_in,
  output logic [7:0] cmd_code_out,
  output logic page_out,
  output logic write_strobe_out,
  output logic read_strobe_out,
  output logic [7:0] write_data_out,
  output logic mask_write_out,
  output logic clear_faults_out,
  output logic erase_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] got = 16'h0000; // last read result, unknown if no answer
  initial begin
    {cmd_code_out, page_out, write_strobe_out, read_strobe_out} = 11'h0;
    {write_data_out, mask_write_out, clear_faults_out, erase_out} = 11'h0;
  end
  // released qualifiers show the inverse, never a lucky stale value
  // page rides with the write, since w1c of paged bytes depends on it
  task automatic wr(input logic [7:0] c, input logic p, input logic [7:0] d, input logic m);
    @(negedge clock_in);
    {cmd_code_out, page_out, write_data_out, mask_write_out, write_strobe_out} =
      {c, p, d, m, 1'b1};
    @(negedge clock_in);
    {cmd_code_out, page_out, write_data_out, mask_write_out, write_strobe_out} =
      {~c, ~p, ~d, 2'b00};
  endtask
  // answer is taken in the one cycle that it stands
  task automatic rd(input logic [7:0] c, input logic p);
    @(negedge clock_in);
    {cmd_code_out, page_out, read_strobe_out} = {c, p, 1'b1};
    @(negedge clock_in);
    {cmd_code_out, page_out, read_strobe_out} = {~c, ~p, 1'b0};
    got = read_valid_in ? read_data_in : 16'hxxxx;
  endtask
  task automatic pulse(input logic erase);
    @(negedge clock_in);
    {clear_faults_out, erase_out} = {~erase, erase};
    @(negedge clock_in);
    {clear_faults_out, erase_out} = 2'b00;
  endtask
endmodule
`default_nettype wire

// ===== sim/test_pfsb_fault_status_bank.sv
// self-checking bench: host model drives the bank, events come from here.
// assumes design, checker and host model are compiled first.
`default_nettype none
`include "pfsb_consts.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR at %0t: got %h expected %h", $time, (g), (e)); end end
module test_pfsb_fault_status_bank;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in = 1'b0;
  logic srst_in = 1'b1;
  logic [7:0] ev [0:8] = '{default: 8'h00}; // vout0,vout1,iout0,iout1,input,temp0,temp1,cml,vend
  int num_errors = 0;
  int tests_run = 0;
  logic [15:0] pins = 16'hffff; // live pin levels toward the bank
  logic [7:0] comm = 8'hff; // live common flags toward the bank
  wire [7:0] cmd, wdata;
  wire page, wstb, rstb, mwr, clr, erase, rvalid, alert_n_out, vendor_summary_out;
  wire [15:0] rdata;
  logic [7:0] codes [0:7] = '{`PFSB_CMD_VOUT, `PFSB_CMD_IOUT, `PFSB_CMD_INPUT, `PFSB_CMD_TEMP,
    `PFSB_CMD_CML, `PFSB_CMD_VEND, `PFSB_CMD_PINS, `PFSB_CMD_COMMON};
  logic [7:0] sup [0:5] = '{`PFSB_SUP_VOUT, `PFSB_SUP_IOUT, `PFSB_SUP_INPUT, `PFSB_SUP_TEMP,
    `PFSB_SUP_CML, `PFSB_SUP_VEND};
  int evi [0:5] = '{0, 2, 4, 5, 7, 8}; // event input of each status kind
  always #10 clock_in = ~clock_in;
  pfsb_host_model i_pfsb_host_model (.clock_in(clock_in), .read_data_in(rdata),
    .read_valid_in(rvalid), .cmd_code_out(cmd), .page_out(page), .write_strobe_out(wstb),
    .read_strobe_out(rstb), .write_data_out(wdata), .mask_write_out(mwr),
    .clear_faults_out(clr), .erase_out(erase));
  pfsb_fault_status_bank i_pfsb_fault_status_bank (.clock_in(clock_in), .srst_in(srst_in),
    .cmd_code_in(cmd), .page_in(page), .write_strobe_in(wstb), .read_strobe_in(rstb),
    .write_data_in(wdata), .mask_write_in(mwr), .clear_faults_in(clr),
    .fault_history_erase_cmd_in(erase), .vout_event0_in(ev[0]), .vout_event1_in(ev[1]),
    .iout_event0_in(ev[2]), .iout_event1_in(ev[3]), .input_event_in(ev[4]),
    .temp_event0_in(ev[5]), .temp_event1_in(ev[6]), .cml_event_in(ev[7]),
    .vend_event_in(ev[8]), .pin_state_in(pins), .common_flags_in(comm),
    .read_data_out(rdata), .read_valid_out(rvalid), .alert_n_out(alert_n_out),
    .vendor_summary_out(vendor_summary_out));
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic settle; // covers two sync flops, latch and alert register
    repeat (6) @(negedge clock_in);
  endtask
  task automatic fire(input int i, input logic [7:0] v);
    ev[i] = v;
    settle();
    ev[i] = 8'h00;
    settle();
  endtask
  task automatic rdc(input logic [7:0] c, input logic p, input logic [15:0] e);
    i_pfsb_host_model.rd(c, p);
    `CHK(i_pfsb_host_model.got, e)
  endtask
  task automatic wrc(input logic [7:0] c, input logic p, input logic [7:0] d, input logic m);
    i_pfsb_host_model.wr(c, p, d, m);
    repeat (2) @(negedge clock_in);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge clock_in);
    srst_in = 1'b0;
    for (int i = 0; i < 8; i++)
      rdc(codes[i], 1'b0, (i == 6) ? 16'hcfff : (i == 7) ? 16'h00fb : 16'h0000);
    for (int k = 0; k < 6; k++) begin
      fire(evi[k], 8'hff);
      `CHK(alert_n_out, 1'b0)
      rdc(codes[k], 1'b0, {8'h00, sup[k]});
      if (k == 5) `CHK(vendor_summary_out, 1'b1)
      rdc(codes[k], 1'b1, (k == 0 || k == 1 || k == 3) ? 16'h0 : {8'h00, sup[k]});
      wrc(codes[k], 1'b0, 8'h80, 1'b0);
      rdc(codes[k], 1'b0, {8'h00, sup[k] & 8'h7f});
      wrc(codes[k], 1'b0, 8'hff, 1'b0);
      rdc(codes[k], 1'b0, (k == 5) ? 16'h0008 : 16'h0000);
      `CHK(alert_n_out, k != 5)
    end
    i_pfsb_host_model.pulse(1'b1);
    rdc(`PFSB_CMD_VEND, 1'b0, 16'h0000);
    `CHK(vendor_summary_out, 1'b0)
    $display("latch and clear test done");
    fire(4, 8'h08);
    ev[4] = 8'h08;
    settle();
    rdc(`PFSB_CMD_INPUT, 1'b0, 16'h0008);
    `CHK(alert_n_out, 1'b1)
    ev[4] = 8'h00;
    settle();
    rdc(`PFSB_CMD_INPUT, 1'b0, 16'h0000);
    fire(8, 8'h11);
    `CHK(alert_n_out, 1'b1)
    wrc(`PFSB_CMD_TEMP, 1'b0, 8'h40, 1'b1);
    fire(5, 8'h40);
    `CHK(alert_n_out, 1'b1)
    rdc(`PFSB_CMD_TEMP, 1'b0, 16'h0040);
    $display("live bit and mask test done");
    fire(1, 8'h80);
    rdc(`PFSB_CMD_VOUT, 1'b1, 16'h0080);
    wrc(`PFSB_CMD_VOUT, 1'b0, 8'h80, 1'b0);
    rdc(`PFSB_CMD_VOUT, 1'b1, 16'h0080);
    wrc(`PFSB_CMD_VOUT, 1'b1, 8'h80, 1'b0);
    rdc(`PFSB_CMD_VOUT, 1'b1, 16'h0000);
    // host sees memory/processor faults come straight back and would stop
    ev[7] = 8'h18;
    settle();
    wrc(`PFSB_CMD_CML, 1'b0, 8'h18, 1'b0);
    rdc(`PFSB_CMD_CML, 1'b0, 16'h0018);
    ev[7] = 8'h00;
    settle();
    wrc(`PFSB_CMD_CML, 1'b0, 8'h18, 1'b0);
    rdc(`PFSB_CMD_CML, 1'b0, 16'h0000);
    $display("page write and persistent fault test done");
    ev[2] = 8'h80;
    settle();
    i_pfsb_host_model.pulse(1'b0);
    `CHK(alert_n_out, 1'b1)
    settle();
    `CHK(alert_n_out, 1'b0)
    rdc(`PFSB_CMD_IOUT, 1'b0, 16'h0080);
    pins = 16'h3a5c;
    comm = 8'h24;
    settle();
    rdc(`PFSB_CMD_PINS, 1'b0, 16'h0a5c);
    wrc(`PFSB_CMD_COMMON, 1'b0, 8'hff, 1'b0);
    rdc(`PFSB_CMD_COMMON, 1'b0, 16'h0020);
    rdc(8'h55, 1'b0, 16'h0000);
    $display("clear-all and read-only test done");
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge clock_in);
    num_errors++;
    give_verdict();
  end
endmodule
bind pfsb_fault_status_bank pfsb_props i_pfsb_props (.clock_in(clock_in), .srst_in(srst_in),
  .cmd_code_in(cmd_code_in), .read_strobe_in(read_strobe_in),
  .clear_faults_in(clear_faults_in), .read_data_out(read_data_out),
  .read_valid_out(read_valid_out), .alert_n_out(alert_n_out));
`default_nettype wire
